// ===== core/exec_defs.svh
// Constants for the shift, move and indirect load execution block.
// Assumes inclusion by the package and the modules that use these names.
// Overview of operation
// - Right shift moves bits down, bit0 to carry.
// - Right shift always loads zero into bit7.
// - Destination bit 0 selects W, 1 selects file.
// - Move copies file unchanged, updates zero flag.
// - Indirect load puts addressed byte into W, sets zero.
// - One of two pointers, four update codes.
// - Pre codes adjust pointer before the access.
// - Offset form adds signed offset, pointer kept.
// - Afterwards pointer plus one, minus one, or unchanged.
// - Window register redirects to the pointed address.
// - Pointer wraps modulo sixteen bits.
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

// Register byte offsets on the register bus.
`define REG_W 5'h00
`define REG_STATUS 5'h04
`define REG_PTR0 5'h08
`define REG_PTR1 5'h0C
`define REG_BANK 5'h10
`define REG_STATE 5'h14

// Status register field positions.
`define STATUS_C_BIT 0
`define STATUS_Z_BIT 1

// Reset values.
`define RST_W 8'h00
`define RST_PTR 16'h0000
`define RST_BANK 6'h00

// File addresses of the two indirect windows.
`define WIN0_ADDR 7'h00
`define WIN1_ADDR 7'h01

// Pointer update codes.
`define MODE_PRE_INC 2'h0
`define MODE_PRE_DEC 2'h1
`define MODE_POST_INC 2'h2
`define MODE_POST_DEC 2'h3

`endif

// ===== core/exec_pkg.sv
// Types shared by the execution block and its pointer stepper.
// Assumes the constants header sits beside it.
`include "exec_defs.svh"
package exec_pkg;

    // Decoded operation presented by the instruction decoder.
    typedef enum logic [1:0] {
        LOGICAL_RIGHT_SHIFT_OP,
        MOVE_FILE_OP,
        INDIRECT_LOAD_OP,
        RESERVED_OP
    } op_t;

    // Execution sequence, four clocks per instruction cycle.
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXEC, ST_WRITE} state_t;

    // All state of the execution block.
    typedef struct packed {
        state_t state;
        op_t op;
        logic dest;
        logic ptr_sel;
        logic [7:0] w;
        logic carry;
        logic zero;
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        logic [5:0] bank;
        logic [15:0] ptr_next;
        logic [15:0] mem_addr;
        logic mem_read;
        logic mem_write;
        logic [7:0] mem_wdata;
        logic done;
        logic ack;
        logic [31:0] rdata;
    } exec_state_t;

endpackage : exec_pkg

// ===== core/pointer_step.sv
// Effective address and follow-up value of one indirect pointer.
// Assumes the pointer, code and offset are stable for the cycle.
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.svh"
module pointer_step
    import exec_pkg::*;
#(
    parameter int PTR_W = 16,
    parameter int OFF_W = 6
) (
    input wire logic [PTR_W-1:0] ptr,
    input wire logic [1:0] mode,
    input wire logic rel,
    input wire logic [OFF_W-1:0] offset,
    output logic [PTR_W-1:0] eff_addr,
    output logic [PTR_W-1:0] ptr_next
);
    logic [PTR_W-1:0] plus_one;
    logic [PTR_W-1:0] minus_one;
    logic [PTR_W-1:0] sext;

    // Sixteen bit arithmetic wraps at both ends by itself.
    assign plus_one = ptr + PTR_W'(1);
    assign minus_one = ptr - PTR_W'(1);
    assign sext = {{(PTR_W-OFF_W){offset[OFF_W-1]}}, offset};

    // Address used for the access and the value kept afterwards.
    always_comb begin
        eff_addr = ptr;
        ptr_next = ptr;
        if (rel) begin
            eff_addr = ptr + sext;
            ptr_next = ptr;
        end else begin
            case (mode)
                `MODE_PRE_INC: begin
                    eff_addr = plus_one;
                    ptr_next = plus_one;
                end
                `MODE_PRE_DEC: begin
                    eff_addr = minus_one;
                    ptr_next = minus_one;
                end
                `MODE_POST_INC: begin
                    ptr_next = plus_one;
                end
                default: begin
                    ptr_next = minus_one;
                end
            endcase
        end
    end
endmodule : pointer_step
`default_nettype wire

// ===== core/shift_move_indirect_exec.sv
// Execution datapath for right shift, move file and indirect load.
// Assumes a decoder that holds an instruction until it is taken, a data
// memory that returns read data the cycle after a read pulse, and an
// Avalon-MM master on the register bus.
//
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.svh"
module shift_move_indirect_exec
    import exec_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic instr_valid,
    output logic instr_ready,
    input wire op_t instr_op,
    input wire logic [6:0] instr_file,
    input wire logic instr_dest,
    input wire logic instr_ptr_sel,
    input wire logic [1:0] instr_mode,
    input wire logic instr_rel,
    input wire logic [5:0] instr_offset,
    output logic instr_done,
    output logic [15:0] mem_addr,
    output logic mem_read,
    output logic mem_write,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [7:0] w_value,
    output logic carry_flag,
    output logic zero_flag
);
    exec_state_t q;
    exec_state_t d;
    logic [15:0] sel_ptr;
    logic [15:0] step_ea;
    logic [15:0] step_next;
    logic bus_req;

    // Merge the two low byte lanes of a bus write into a 16-bit value.
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : merge16

    // Pointer chosen by the index bit of the incoming instruction.
    assign sel_ptr = instr_ptr_sel ? q.ptr1 : q.ptr0;

    // Effective address and the pointer value to keep afterwards.
    pointer_step #(
        .PTR_W(16),
        .OFF_W(6)
    ) u_step (
        .ptr(sel_ptr),
        .mode(instr_mode),
        .rel(instr_rel),
        .offset(instr_offset),
        .eff_addr(step_ea),
        .ptr_next(step_next)
    );

    assign bus_req = avs_read | avs_write;

    // Next-state logic for the sequencer, the datapath and the bus slave.
    always_comb begin
        logic [7:0] opnd;
        logic [7:0] res;
        logic is_win;
        logic win_sel;
        logic [15:0] win_ptr;
        logic [15:0] direct;
        opnd = mem_rdata;
        res = mem_rdata;
        is_win = 1'b0;
        win_sel = 1'b0;
        win_ptr = q.ptr0;
        direct = {3'h0, q.bank, instr_file};
        d = q;
        d.mem_read = 1'b0;
        d.mem_write = 1'b0;
        d.done = 1'b0;
        d.ack = 1'b0;
        case (q.state)
            ST_IDLE: begin
                if (instr_valid && !q.ack) begin
                    // Take the instruction and start the operand read.
                    d.op = instr_op;
                    d.dest = instr_dest;
                    d.ptr_sel = instr_ptr_sel;
                    d.ptr_next = step_next;
                    win_sel = (instr_file == `WIN1_ADDR);
                    is_win = (instr_file == `WIN0_ADDR) || win_sel;
                    win_ptr = win_sel ? q.ptr1 : q.ptr0;
                    if (instr_op == INDIRECT_LOAD_OP) begin
                        d.mem_addr = step_ea;
                    end else if (is_win) begin
                        d.mem_addr = win_ptr;
                    end else begin
                        d.mem_addr = direct;
                    end
                    d.mem_read = (instr_op != RESERVED_OP);
                    d.state = ST_READ;
                end else if (bus_req && !q.ack) begin
                    // Latch the read data now; waitrequest drops in the next cycle.
                    d.ack = 1'b1;
                    d.rdata = 32'h0000_0000;
                    if (avs_read) begin
                        case (avs_address)
                            `REG_W: begin
                                d.rdata = {24'h00_0000, q.w};
                            end
                            `REG_STATUS: begin
                                d.rdata[`STATUS_C_BIT] = q.carry;
                                d.rdata[`STATUS_Z_BIT] = q.zero;
                            end
                            `REG_PTR0: begin
                                d.rdata = {16'h0000, q.ptr0};
                            end
                            `REG_PTR1: begin
                                d.rdata = {16'h0000, q.ptr1};
                            end
                            `REG_BANK: begin
                                d.rdata = {26'h000_0000, q.bank};
                            end
                            `REG_STATE: begin
                                d.rdata = {30'h0000_0000, q.state};
                            end
                            default: begin
                                d.rdata = 32'h0000_0000;
                            end
                        endcase
                    end
                end else if (q.ack && avs_write) begin
                    // A write lands only at the edge where waitrequest is seen low.
                    case (avs_address)
                        `REG_W: begin
                            if (avs_byteenable[0]) begin
                                d.w = avs_writedata[7:0];
                            end
                        end
                        `REG_STATUS: begin
                            if (avs_byteenable[0]) begin
                                d.carry = avs_writedata[`STATUS_C_BIT];
                                d.zero = avs_writedata[`STATUS_Z_BIT];
                            end
                        end
                        `REG_PTR0: begin
                            d.ptr0 = merge16(q.ptr0, avs_writedata, avs_byteenable);
                        end
                        `REG_PTR1: begin
                            d.ptr1 = merge16(q.ptr1, avs_writedata, avs_byteenable);
                        end
                        `REG_BANK: begin
                            if (avs_byteenable[0]) begin
                                d.bank = avs_writedata[5:0];
                            end
                        end
                        default: begin
                            // Unmapped and read-only addresses ignore writes.
                            d.ack = 1'b0;
                        end
                    endcase
                end
            end
            ST_READ: begin
                // The memory sees the read pulse during this cycle.
                d.state = ST_EXEC;
            end
            ST_EXEC: begin
                // Operand byte is valid now; compute and retire.
                opnd = mem_rdata;
                case (q.op)
                    LOGICAL_RIGHT_SHIFT_OP: begin
                        res = {1'b0, opnd[7:1]};
                        d.carry = opnd[0];
                        d.zero = (res == 8'h00);
                        if (q.dest) begin
                            d.mem_write = 1'b1;
                            d.mem_wdata = res;
                        end else begin
                            d.w = res;
                        end
                    end
                    MOVE_FILE_OP: begin
                        res = opnd;
                        d.zero = (res == 8'h00);
                        if (q.dest) begin
                            d.mem_write = 1'b1;
                            d.mem_wdata = res;
                        end else begin
                            d.w = res;
                        end
                    end
                    INDIRECT_LOAD_OP: begin
                        d.w = opnd;
                        d.zero = (opnd == 8'h00);
                        if (q.ptr_sel) begin
                            d.ptr1 = q.ptr_next;
                        end else begin
                            d.ptr0 = q.ptr_next;
                        end
                    end
                    default: begin
                        res = opnd;
                    end
                endcase
                d.state = ST_WRITE;
            end
            ST_WRITE: begin
                // Write-back pulse is on the memory port now.
                d.done = 1'b1;
                d.state = ST_IDLE;
            end
            default: begin
                d.state = ST_IDLE;
            end
        endcase
    end

    // State register with synchronous active-low reset.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q <= '0;
            q.state <= ST_IDLE;
            q.w <= `RST_W;
            q.ptr0 <= `RST_PTR;
            q.ptr1 <= `RST_PTR;
            q.bank <= `RST_BANK;
        end else begin
            q <= d;
        end
    end

    // Ready and waitrequest are combinational; done and the data outputs come from the state.
    assign instr_ready = (q.state == ST_IDLE) && !q.ack;
    assign avs_waitrequest = bus_req && !q.ack;
    assign avs_readdata = q.rdata;
    assign instr_done = q.done;
    assign mem_addr = q.mem_addr;
    assign mem_read = q.mem_read;
    assign mem_write = q.mem_write;
    assign mem_wdata = q.mem_wdata;
    assign w_value = q.w;
    assign carry_flag = q.carry;
    assign zero_flag = q.zero;

endmodule : shift_move_indirect_exec
`default_nettype wire

// ===== tb/shift_move_indirect_exec_properties.sv
// Assertions on the instruction and data memory ports of the execution block.
// Assumes it is bound into the execution block and shares its clock and reset.
`timescale 1ns/1ps
`default_nettype none
module exec_checker
    import exec_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire op_t instr_op,
    input wire logic [6:0] instr_file,
    input wire logic instr_dest,
    input wire logic instr_done,
    input wire logic [15:0] mem_addr,
    input wire logic mem_read,
    input wire logic mem_write,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] w_value,
    input wire logic carry_flag,
    input wire logic zero_flag
);
    // An instruction is taken when offered while the block is ready.
    logic take;
    assign take = instr_valid && instr_ready;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    AST_DONE_FOUR: assert property (take |-> ##4 instr_done)
        else $error("done missing four cycles after take");
    AST_BUSY: assert property (take |=> !instr_ready [*3])
        else $error("new instruction accepted while busy");
    AST_DIRECT_ADDR: assert property (take && instr_op inside {LOGICAL_RIGHT_SHIFT_OP, MOVE_FILE_OP}
        && instr_file > 7'h01 |=> mem_read && mem_addr[6:0] == $past(instr_file) && mem_addr[15:13] == 3'h0)
        else $error("direct file address wrong");
    AST_SHIFT_TO_W: assert property (take && instr_op == LOGICAL_RIGHT_SHIFT_OP && !instr_dest |-> ##3
        w_value == {1'b0, $past(mem_rdata[7:1])} && carry_flag == $past(mem_rdata[0])
        && zero_flag == (w_value == 8'h00) && !mem_write)
        else $error("shift result to accumulator wrong");
    AST_SHIFT_TO_FILE: assert property (take && instr_op == LOGICAL_RIGHT_SHIFT_OP && instr_dest |-> ##3
        mem_write && mem_wdata == {1'b0, $past(mem_rdata[7:1])} && carry_flag == $past(mem_rdata[0]))
        else $error("shift result to file wrong");
    AST_MOVE: assert property (take && instr_op == MOVE_FILE_OP |-> ##3
        zero_flag == ($past(mem_rdata) == 8'h00) && mem_write == $past(instr_dest, 3))
        else $error("move zero flag or destination wrong");
    AST_LOAD: assert property (take && instr_op == INDIRECT_LOAD_OP |-> ##3
        w_value == $past(mem_rdata) && zero_flag == (w_value == 8'h00) && !mem_write)
        else $error("indirect load result wrong");
    AST_WRITE_SAME: assert property (mem_write |-> $past(mem_read, 2) && mem_addr == $past(mem_addr, 2))
        else $error("write back not to the operand address");
endmodule : exec_checker
bind shift_move_indirect_exec exec_checker u_chk (.clock, .rst_n, .instr_valid, .instr_ready, .instr_op,
    .instr_file, .instr_dest, .instr_done, .mem_addr, .mem_read, .mem_write, .mem_wdata, .mem_rdata,
    .w_value, .carry_flag, .zero_flag);
`default_nettype wire

// ===== tb/data_mem_model.sv
// Data memory on the far side of the execution block.
// Assumes one read or write pulse per access, answered in the next cycle.
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
    input wire logic clock,
    input wire logic [15:0] mem_addr,
    input wire logic mem_read,
    input wire logic mem_write,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] store [0:65535];
    // Unwritten bytes follow an address pattern.
    initial begin
        for (int i = 0; i < 65536; i++) begin
            store[i] = 8'(i) + 8'(i >> 8) * 8'h03 + 8'h3C;
        end
    end
    // Reads answer in the next cycle; each idle cycle inverts the byte on mem_rdata.
    always @(posedge clock) begin
        if (mem_write) begin
            store[mem_addr] <= mem_wdata;
        end
        if (mem_read) begin
            mem_rdata <= store[mem_addr];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule : data_mem_model
`default_nettype wire

// ===== tb/shift_move_indirect_exec_tb_top.sv
// Self-checking bench for the execution block with a data memory model.
// Assumes the register bus map and four-cycle instruction timing of the block.
`timescale 1ns/1ps
`default_nettype none
module shift_move_indirect_exec_tb_top
    import exec_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid = 1'b0;
    op_t instr_op = LOGICAL_RIGHT_SHIFT_OP;
    logic [6:0] instr_file = 7'h00;
    logic instr_dest = 1'b0;
    logic instr_ptr_sel = 1'b0;
    logic [1:0] instr_mode = 2'h0;
    logic instr_rel = 1'b0;
    logic [5:0] instr_offset = 6'h00;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic instr_ready, instr_done, mem_read, mem_write, avs_waitrequest, carry_flag, zero_flag;
    logic [15:0] mem_addr, p, q;
    logic [7:0] mem_wdata, mem_rdata, w_value, e;
    logic [31:0] avs_readdata, rd;
    logic [1:0] m;
    int n_mismatch = 0;
    int total_checks = 0;
    int k;
    always #5 clock = ~clock;
    shift_move_indirect_exec dut (.clock, .rst_n, .instr_valid, .instr_ready, .instr_op, .instr_file,
        .instr_dest, .instr_ptr_sel, .instr_mode, .instr_rel, .instr_offset, .instr_done, .mem_addr,
        .mem_read, .mem_write, .mem_wdata, .mem_rdata, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .w_value, .carry_flag, .zero_flag);
    data_mem_model mem (.clock, .mem_addr, .mem_read, .mem_write, .mem_wdata, .mem_rdata);

    function automatic logic [7:0] exp_byte(input logic [15:0] a);
        return a[7:0] + a[15:8] * 8'h03 + 8'h3C;
    endfunction : exp_byte

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk

    // Waits on rising edges for bus answer (0), ready (1) or done (2), with a bound.
    task automatic await(input int which);
        for (int i = 0; i < 40; i++) begin
            @(posedge clock);
            if ((which == 0 && avs_waitrequest === 1'b0) || (which == 1 && instr_ready === 1'b1)
                || (which == 2 && instr_done === 1'b1)) begin
                return;
            end
        end
        $display("Error at %0t: wait timed out", $time);
        n_mismatch++;
        wrap_up();
    endtask : await

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        await(0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic run(input op_t op, input logic [6:0] f, input logic d, input logic ps, input logic [1:0] md,
        input logic r, input logic [5:0] o);
        @(posedge clock);
        instr_op <= op;
        instr_file <= f;
        instr_dest <= d;
        instr_ptr_sel <= ps;
        instr_mode <= md;
        instr_rel <= r;
        instr_offset <= o;
        instr_valid <= 1'b1;
        await(1);
        instr_valid <= 1'b0;
        await(2);
    endtask : run

    // Main sequence: reset values, shift and move, indirect loads, offsets and the window.
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        for (k = 0; k < 7; k++) begin
            bus(1'b0, 5'(k * 4), 32'h0, 4'hF);
            chk(rd, 32'h0);
        end
        e = exp_byte(16'h02A3);
        bus(1'b1, 5'h10, 32'h5, 4'hF);
        run(LOGICAL_RIGHT_SHIFT_OP, 7'h23, 1'b1, 1'b0, 2'h0, 1'b0, 6'h00);
        chk(w_value, 8'h00);
        chk({carry_flag, zero_flag}, {e[0], e[7:1] == 7'h00});
        run(MOVE_FILE_OP, 7'h23, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00);
        chk(w_value, {1'b0, e[7:1]});
        run(LOGICAL_RIGHT_SHIFT_OP, 7'h23, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00);
        chk({w_value, carry_flag}, {2'h0, e[7:2], e[1]});
        bus(1'b1, 5'h10, 32'h11, 4'hF);
        run(MOVE_FILE_OP, 7'h2C, 1'b1, 1'b0, 2'h0, 1'b0, 6'h00);
        chk({w_value, zero_flag}, {2'h0, e[7:2], 1'b1});
        for (k = 0; k < 8; k++) begin
            m = 2'(k);
            p = m[0] ? 16'h0000 : 16'hFFFF;
            q = m[0] ? p - 16'h1 : p + 16'h1;
            bus(1'b1, k[2] ? 5'h0C : 5'h08, {16'h0, p}, 4'hF);
            run(INDIRECT_LOAD_OP, 7'h00, 1'b0, k[2], m, 1'b0, 6'h00);
            chk(w_value, exp_byte(m[1] ? p : q));
            chk(zero_flag, exp_byte(m[1] ? p : q) == 8'h00);
            bus(1'b0, k[2] ? 5'h0C : 5'h08, 32'h0, 4'hF);
            chk(rd, {16'h0, q});
        end
        bus(1'b1, 5'h08, 32'h1234, 4'h1);
        bus(1'b0, 5'h08, 32'h0, 4'hF);
        chk(rd, 32'hFF34);
        bus(1'b1, 5'h0C, 32'h1000, 4'hF);
        for (k = 0; k < 2; k++) begin
            run(INDIRECT_LOAD_OP, 7'h00, 1'b0, 1'b1, 2'h2, 1'b1, k ? 6'h1F : 6'h20);
            chk(w_value, exp_byte(k ? 16'h101F : 16'h0FE0));
        end
        run(LOGICAL_RIGHT_SHIFT_OP, 7'h01, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00);
        chk(w_value, exp_byte(16'h1000) >> 1);
        bus(1'b0, 5'h0C, 32'h0, 4'hF);
        chk(rd, 32'h1000);
        bus(1'b1, 5'h08, 32'h08AC, 4'hF);
        run(MOVE_FILE_OP, 7'h00, 1'b1, 1'b0, 2'h0, 1'b0, 6'h00);
        chk({w_value, zero_flag}, {8'h36, 1'b1});
        run(RESERVED_OP, 7'h23, 1'b0, 1'b0, 2'h0, 1'b0, 6'h00);
        chk({w_value, zero_flag}, {8'h36, 1'b1});
        run(INDIRECT_LOAD_OP, 7'h00, 1'b0, 1'b0, 2'h2, 1'b0, 6'h00);
        chk({w_value, zero_flag}, {8'h00, 1'b1});
        bus(1'b0, 5'h08, 32'h0, 4'hF);
        chk(rd, 32'h08AD);
        wrap_up();
    end
endmodule : shift_move_indirect_exec_tb_top
`default_nettype wire
